//--- src/lbsdp_pkg.sv
// Shared constants and types for the local bus slave and DMA port
package lbsdp_pkg;
	localparam int unsigned DATA_W          = 32;
	localparam int unsigned ADDR_W          = 32;
	localparam int unsigned LINE_ALIGN_BITS = 4;
	localparam int unsigned BURST_BEATS     = 4;
	localparam int unsigned UNALIGNED_WAITS = 1;
	localparam int unsigned REG_SYNC_BASE   = 2;
	localparam int unsigned WAIT_W          = 3;
	localparam int unsigned BEAT_W          = 3;
	localparam int unsigned BUF_DEPTH       = 2;
	localparam logic [LINE_ALIGN_BITS-1:0] LINE_OFFSET_ZERO = 4'h0;

	// Processor bus styles: first, second and third
	typedef enum logic [1:0] {
		LBSDP_STYLE_FIRST,
		LBSDP_STYLE_SECOND,
		LBSDP_STYLE_THIRD
	} lbsdp_style_t;

	typedef enum logic [1:0] {
		LBSDP_ARB_IDLE,
		LBSDP_ARB_WAIT,
		LBSDP_ARB_OWN
	} lbsdp_arb_t;

	typedef enum logic [2:0] {
		LBSDP_CYC_IDLE,
		LBSDP_CYC_SLV_WAIT,
		LBSDP_CYC_SLV_BEAT,
		LBSDP_CYC_DMA_SGL,
		LBSDP_CYC_DMA_DUAL,
		LBSDP_CYC_DMA_ACK
	} lbsdp_cyc_state_t;

	// Attributes of a cycle captured at transfer start
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic              burst;
		logic              reg_acc;
	} lbsdp_cyc_t;
endpackage

//--- src/lbsdp_buf2.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module lbsdp_buf2 #(
	parameter int unsigned W     = 32,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clk_sys_in,
	input  wire logic         rst_in,
	// Fill side
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	// Drain side
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	if (DEPTH != 2) begin : g_chk
		$error("lbsdp_buf2 supports depth 2 only");
	end

	logic [W-1:0] mem_r [DEPTH];
	logic         wr_idx_r;
	logic         rd_idx_r;
	logic [1:0]   count_r;
	logic         push;
	logic         pop;

	assign in_ready_out  = (count_r != 2'h2);
	assign out_valid_out = (count_r != 2'h0);
	assign out_data_out  = mem_r[rd_idx_r];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_r[wr_idx_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wr_idx_r <= 1'b0;
			rd_idx_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			if (push) begin
				wr_idx_r <= ~wr_idx_r;
			end
			if (pop) begin
				rd_idx_r <= ~rd_idx_r;
			end
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

//--- src/lbsdp_port.sv
// Local bus slave timing, arbitration and DMA handshake
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Take bus ownership only after other master negates busy and grant-ack.
// RULE2: Second style slave burst write, unaligned start: at least one wait.
// RULE3: Third style delayed burst read, unaligned start: insert wait states.
// RULE4: Third style posted burst write, unaligned start: insert wait states.
// RULE5: Register access master waits for acknowledge; wait count varies.
// RULE6: Single DMA: processor acks, device samples; dual: device acks.
// RULE7: DMA terminate input ignored in all second style DMA cycles.
// RULE8: No address decode in DMA; window select alone picks single/dual.
// RULE9: Dual DMA never retries or errors; each ends with normal ack.
// RULE10: Request out for service; ack strobe with start; data per direction.
module lbsdp_port
	import lbsdp_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              rst_in,
	// Configuration
	input  wire lbsdp_style_t      bus_style_in,
	// Arbitration
	input  wire logic              own_req_in,
	input  wire logic              bus_busy_n_in,
	input  wire logic              bus_grant_ack_n_in,
	output logic                   bus_busy_n_out,
	output logic                   bus_busy_oe_n_out,
	output logic                   bus_owned_out,
	// Bus cycle inputs and data bus outputs
	input  wire logic              transfer_start_n_in,
	input  wire logic              pci_window_select_n_in,
	input  wire logic              reg_select_n_in,
	input  wire logic              dma_acknowledge_n_in,
	input  wire logic              dma_done_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              write_in,
	input  wire logic              burst_in,
	input  wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe_n_out,
	// Termination pins
	input  wire logic              transfer_ack_n_in,
	output logic                   transfer_ack_n_out,
	output logic                   transfer_ack_oe_n_out,
	input  wire logic              transfer_error_ack_n_in,
	output logic                   transfer_error_ack_n_out,
	output logic                   transfer_error_ack_oe_n_out,
	input  wire logic              retry_request_n_in,
	output logic                   retry_request_n_out,
	output logic                   retry_request_oe_n_out,
	// DMA request
	output logic                   dma_request_n_out,
	// User control
	input  wire logic              dma_enable_in,
	input  wire logic              dma_to_bus_in,
	// Slave data to and from the core
	output logic                   slave_beat_out,
	output logic [DATA_W-1:0]      slave_wdata_out,
	input  wire logic [DATA_W-1:0] slave_rdata_in,
	// DMA read stream (core to bus)
	input  wire logic              rd_valid_in,
	input  wire logic [DATA_W-1:0] rd_data_in,
	output logic                   rd_ready_out,
	// DMA write stream (bus to core)
	output logic                   wr_valid_out,
	output logic [DATA_W-1:0]      wr_data_out,
	input  wire logic              wr_ready_in
);
	lbsdp_arb_t       arb_r;
	lbsdp_cyc_state_t st_r;
	lbsdp_cyc_t       cyc_r;
	logic [WAIT_W-1:0] wait_r;
	logic [BEAT_W-1:0] beat_r;
	logic              phase_r;
	logic              dma_request_out_r;
	logic [DATA_W-1:0] data_r;
	logic              err_r;
	logic              slv_start;
	logic              dma_start;
	logic              unaligned;
	logic              needs_wait;
	logic [WAIT_W-1:0] first_wait;
	logic              sgl_done;
	logic              dma_push;
	logic              wbuf_ready;

	// Arbitration
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			arb_r <= LBSDP_ARB_IDLE;
		end else begin
			unique case (arb_r)
			LBSDP_ARB_IDLE: begin
				if (own_req_in && st_r == LBSDP_CYC_IDLE) begin
					arb_r <= LBSDP_ARB_WAIT;
				end
			end
			LBSDP_ARB_WAIT: begin
				if (!own_req_in) begin
					arb_r <= LBSDP_ARB_IDLE;
				end else if (bus_busy_n_in && bus_grant_ack_n_in) begin
					arb_r <= LBSDP_ARB_OWN; // RULE1
				end
			end
			LBSDP_ARB_OWN: arb_r <= own_req_in ? LBSDP_ARB_OWN
				: LBSDP_ARB_IDLE;
			endcase
		end
	end
	assign bus_owned_out     = (arb_r == LBSDP_ARB_OWN);
	assign bus_busy_n_out    = 1'b0;
	assign bus_busy_oe_n_out = !bus_owned_out;

	// Free-running phase models the register synchroniser's jitter
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			phase_r <= 1'b0;
		end else begin
			phase_r <= ~phase_r;
		end
	end

	// Cycle decode; the address is looked at only for slave cycles
	assign dma_start = !transfer_start_n_in && !dma_acknowledge_n_in
		&& st_r == LBSDP_CYC_IDLE; // RULE10
	assign slv_start = !transfer_start_n_in && dma_acknowledge_n_in
		&& (!pci_window_select_n_in || !reg_select_n_in)
		&& st_r == LBSDP_CYC_IDLE && !bus_owned_out;
	assign unaligned = (addr_in[LINE_ALIGN_BITS-1:0] != LINE_OFFSET_ZERO);

	always_comb begin
		needs_wait = 1'b0;
		if (burst_in && unaligned) begin
			unique case (bus_style_in)
			LBSDP_STYLE_SECOND: needs_wait = write_in; // RULE2
			LBSDP_STYLE_THIRD:  needs_wait = 1'b1; // RULE3 RULE4
			default:            needs_wait = 1'b0;
			endcase
		end
	end

	always_comb begin
		if (!reg_select_n_in) begin
			// Variable count: master must wait for the ack
			first_wait = WAIT_W'(REG_SYNC_BASE) + {2'h0, phase_r}; // RULE5
		end else if (needs_wait) begin
			first_wait = WAIT_W'(UNALIGNED_WAITS); // RULE2 RULE3 RULE4
		end else begin
			first_wait = '0;
		end
	end

	// Single DMA ends on the processor's terminations; done is never read
	assign sgl_done = !transfer_ack_n_in || !transfer_error_ack_n_in
		|| !retry_request_n_in; // RULE6 RULE7

	// Cycle state machine
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			st_r   <= LBSDP_CYC_IDLE;
			cyc_r  <= '0;
			wait_r <= '0;
			beat_r <= '0;
		end else begin
			unique case (st_r)
			LBSDP_CYC_IDLE: begin
				if (dma_start) begin
					cyc_r <= '{addr: '0, write: write_in, burst: 1'b0,
						reg_acc: 1'b0};
					// Window select, not the address, picks the mode
					st_r <= pci_window_select_n_in ? LBSDP_CYC_DMA_SGL
						: LBSDP_CYC_DMA_DUAL; // RULE8
				end else if (slv_start) begin
					cyc_r <= '{addr: addr_in, write: write_in,
						burst: burst_in, reg_acc: !reg_select_n_in};
					wait_r <= first_wait;
					beat_r <= burst_in ? BEAT_W'(BURST_BEATS - 1) : '0;
					st_r <= (first_wait == '0) ? LBSDP_CYC_SLV_BEAT
						: LBSDP_CYC_SLV_WAIT;
				end
			end
			LBSDP_CYC_SLV_WAIT: begin
				wait_r <= wait_r - 1'b1;
				if (wait_r == WAIT_W'(1)) begin
					st_r <= LBSDP_CYC_SLV_BEAT;
				end
			end
			LBSDP_CYC_SLV_BEAT: begin
				beat_r <= beat_r - 1'b1;
				if (beat_r == '0) begin
					st_r <= LBSDP_CYC_IDLE;
				end
			end
			LBSDP_CYC_DMA_SGL: begin
				if (sgl_done) begin
					st_r <= LBSDP_CYC_IDLE; // RULE6
				end
			end
			LBSDP_CYC_DMA_DUAL: st_r <= LBSDP_CYC_DMA_ACK;
			LBSDP_CYC_DMA_ACK:  st_r <= LBSDP_CYC_IDLE; // RULE9
			default:            st_r <= LBSDP_CYC_IDLE;
			endcase
		end
	end

	// Terminations the device drives
	assign transfer_ack_n_out    = 1'b0;
	assign transfer_ack_oe_n_out = !(st_r == LBSDP_CYC_SLV_BEAT
		|| st_r == LBSDP_CYC_DMA_ACK); // RULE6 RULE9
	// Error only for a slave cycle with both selects; never in DMA
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			err_r <= 1'b0;
		end else begin
			err_r <= slv_start && !pci_window_select_n_in
				&& !reg_select_n_in; // RULE9
		end
	end
	assign transfer_error_ack_n_out    = 1'b0;
	assign transfer_error_ack_oe_n_out = !err_r;
	assign retry_request_n_out         = 1'b1;
	assign retry_request_oe_n_out      = 1'b1;

	// Data bus
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			data_r          <= '0;
			slave_wdata_out <= '0;
		end else begin
			if (dma_start && !write_in) begin
				data_r <= rd_data_in; // RULE10
			end else if (st_r == LBSDP_CYC_SLV_WAIT
				|| (slv_start && first_wait == '0)) begin
				data_r <= slave_rdata_in;
			end
			if (st_r == LBSDP_CYC_SLV_BEAT && cyc_r.write) begin
				slave_wdata_out <= data_in;
			end
		end
	end
	assign data_out       = data_r;
	assign data_oe_n_out  = cyc_r.write || !(st_r == LBSDP_CYC_SLV_BEAT
		|| st_r == LBSDP_CYC_DMA_SGL || st_r == LBSDP_CYC_DMA_DUAL
		|| st_r == LBSDP_CYC_DMA_ACK);
	assign slave_beat_out = (st_r == LBSDP_CYC_SLV_BEAT);
	// A retried or errored single cycle moves no word
	assign dma_push = cyc_r.write && ((st_r == LBSDP_CYC_DMA_SGL
		&& !transfer_ack_n_in && transfer_error_ack_n_in
		&& retry_request_n_in) || st_r == LBSDP_CYC_DMA_DUAL); // RULE10
	assign rd_ready_out = !cyc_r.write && ((st_r == LBSDP_CYC_DMA_SGL
		&& !transfer_ack_n_in && transfer_error_ack_n_in
		&& retry_request_n_in) || st_r == LBSDP_CYC_DMA_DUAL);

	// DMA bus writes go through the buffer so a slow core loses nothing
	lbsdp_buf2 #(
		.W     (DATA_W),
		.DEPTH (BUF_DEPTH)
	) u_wbuf (
		.clk_sys_in    (clk_sys_in),
		.rst_in        (rst_in),
		.in_valid_in   (dma_push),
		.in_data_in    (data_in),
		.in_ready_out  (wbuf_ready),
		.out_valid_out (wr_valid_out),
		.out_data_out  (wr_data_out),
		.out_ready_in  (wr_ready_in)
	);

	// Request only when the word can be served; buffer full stalls it
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			dma_request_out_r <= 1'b0;
		end else begin
			dma_request_out_r <= dma_enable_in && st_r == LBSDP_CYC_IDLE && !dma_start
				&& (dma_to_bus_in ? rd_valid_in : wbuf_ready); // RULE10
		end
	end
	assign dma_request_n_out = !dma_request_out_r;

	// Checks
	AST_ARB_AFTER_RELEASE: assert property (@(posedge clk_sys_in) // RULE1
		disable iff (rst_in)
		$rose(bus_owned_out) |-> $past(bus_busy_n_in)
			&& $past(bus_grant_ack_n_in))
		else $error("bus taken while other master held it");
	AST_SECOND_WR_WAIT: assert property (@(posedge clk_sys_in) // RULE2
		disable iff (rst_in)
		slv_start && reg_select_n_in && burst_in && write_in && unaligned
			&& bus_style_in == LBSDP_STYLE_SECOND
		|=> transfer_ack_oe_n_out ##1 !transfer_ack_oe_n_out)
		else $error("second style unaligned burst write lacks wait");
	AST_THIRD_RD_WAIT: assert property (@(posedge clk_sys_in) // RULE3
		disable iff (rst_in)
		slv_start && reg_select_n_in && burst_in && !write_in && unaligned
			&& bus_style_in == LBSDP_STYLE_THIRD
		|=> transfer_ack_oe_n_out)
		else $error("third style unaligned burst read lacks wait");
	AST_THIRD_WR_WAIT: assert property (@(posedge clk_sys_in) // RULE4
		disable iff (rst_in)
		slv_start && reg_select_n_in && burst_in && write_in && unaligned
			&& bus_style_in == LBSDP_STYLE_THIRD
		|=> transfer_ack_oe_n_out)
		else $error("third style unaligned burst write lacks wait");
	AST_SGL_NOT_DRIVEN: assert property (@(posedge clk_sys_in) // RULE6
		disable iff (rst_in)
		st_r == LBSDP_CYC_DMA_SGL |-> transfer_ack_oe_n_out)
		else $error("device drove ack in single address DMA");
	AST_DONE_IGNORED: assert property (@(posedge clk_sys_in) // RULE7
		disable iff (rst_in)
		st_r == LBSDP_CYC_DMA_SGL && !sgl_done |=> st_r == LBSDP_CYC_DMA_SGL)
		else $error("single DMA ended without a termination");
	AST_MODE_BY_SELECT: assert property (@(posedge clk_sys_in) // RULE8
		disable iff (rst_in)
		dma_start |=> (st_r == LBSDP_CYC_DMA_DUAL)
			== !$past(pci_window_select_n_in))
		else $error("DMA mode not set by window select");
	AST_DUAL_NORMAL_END: assert property (@(posedge clk_sys_in) // RULE9
		disable iff (rst_in)
		dma_start && !pci_window_select_n_in
		|=> (transfer_error_ack_oe_n_out && retry_request_oe_n_out)[*2]
			##0 !transfer_ack_oe_n_out)
		else $error("dual DMA did not end with a normal ack");
	AST_PUSH_HAS_ROOM: assert property (@(posedge clk_sys_in) // RULE10
		disable iff (rst_in)
		dma_push |-> wbuf_ready)
		else $error("DMA write word lost to full buffer");
	COV_DUAL_READ: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		dma_start && !write_in && !pci_window_select_n_in);
	COV_SGL_WRITE: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		dma_push && st_r == LBSDP_CYC_DMA_SGL);
	COV_UNALIGNED: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		slv_start && burst_in && unaligned);
	COV_ARB_WAIT: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		arb_r == LBSDP_ARB_WAIT ##1 arb_r == LBSDP_ARB_WAIT
		##1 bus_owned_out);
endmodule
`default_nettype wire

//--- test/lbsdp_proc_model.sv
// Processor model standing on the far side of the local bus
`timescale 1ns/1ps
`default_nettype none
module lbsdp_proc_model
	import lbsdp_pkg::*;
(
	// Clock
	input  wire logic              clk_sys_in,
	// Resolved bus lines
	input  wire logic              ta_n_in,
	input  wire logic [DATA_W-1:0] dev_data_in,
	// Cycle lines
	output logic                   start_n_out,
	output logic                   win_n_out,
	output logic                   reg_n_out,
	output logic                   dack_n_out,
	output logic                   done_n_out,
	output logic [ADDR_W-1:0]      addr_out,
	output logic                   write_out,
	output logic                   burst_out,
	output logic [DATA_W-1:0]      data_out,
	// Terminations and other master
	output logic                   ta_n_out,
	output logic                   tea_n_out,
	output logic                   rty_n_out,
	output logic                   bb_n_out,
	output logic                   bus_grant_ack_n_out
);
	initial begin
		{start_n_out, win_n_out, reg_n_out, dack_n_out} = 4'hF;
		{ta_n_out, tea_n_out, rty_n_out, bb_n_out, bus_grant_ack_n_out} = 5'h1F;
		{addr_out, write_out, burst_out} = 34'h0;
		data_out = 32'h0;
		done_n_out = 1'b1;
	end
	// Terminate strobe wanders freely; the device must not care
	always @(posedge clk_sys_in) #1 done_n_out = $urandom_range(1, 0);
	// Other master holds or lets go of the bus
	task automatic other(input logic gack, input logic v);
		@(posedge clk_sys_in) #1;
		if (gack)
			bus_grant_ack_n_out = v;
		else
			bb_n_out = v;
	endtask
	// Kind 0 slave, 1 register, 2 single DMA, 3 dual DMA
	task automatic xfer(input int kind, input logic wr, input logic bst,
		input logic [31:0] a, input logic [31:0] d, input int term,
		input int slow, output int lat, output int beats,
		output logic [31:0] rd);
		int n;
		lat = -1;
		beats = 0;
		n = 0;
		rd = 32'h0;
		@(posedge clk_sys_in) #1;
		start_n_out = 1'b0;
		reg_n_out = (kind != 1);
		dack_n_out = (kind < 2);
		win_n_out = !(kind == 0 || kind == 3);
		{addr_out, write_out, burst_out, data_out} = {a, wr, bst, d};
		// Wait counts vary, so never assume a fixed number
		repeat (24) begin
			@(posedge clk_sys_in);
			n++;
			if (!ta_n_in || !tea_n_out || !rty_n_out) begin
				if (lat < 0) begin
					lat = n - 1;
					rd = dev_data_in;
				end
				beats++;
			end
			if (beats == (bst ? BURST_BEATS : 1))
				break;
			#1;
			start_n_out = (lat >= 0);
			if (kind == 2 && n == slow + 1) begin
				ta_n_out = (term != 0);
				tea_n_out = (term != 1);
				rty_n_out = (term != 2);
			end
		end
		#1;
		{start_n_out, win_n_out, reg_n_out, dack_n_out} = 4'hF;
		{ta_n_out, tea_n_out, rty_n_out} = 3'h7;
		data_out = ~d;
	endtask
endmodule
`default_nettype wire

//--- test/local_bus_slave_dma_port_test.sv
// Self-checking bench for the local bus slave and DMA port
`timescale 1ns/1ps
`default_nettype none
module local_bus_slave_dma_port_test;
	import lbsdp_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	lbsdp_style_t bus_style_in = LBSDP_STYLE_SECOND;
	logic own_req_in = 1'b0;
	logic dma_enable_in = 1'b0;
	logic dma_to_bus_in = 1'b0;
	logic rd_valid_in = 1'b0;
	logic wr_ready_in = 1'b1;
	logic [DATA_W-1:0] slave_rdata_in = 32'h0;
	logic [DATA_W-1:0] rd_data_in = 32'h0;
	wire logic transfer_start_n_in, pci_window_select_n_in, reg_select_n_in;
	wire logic dma_acknowledge_n_in, dma_done_n_in, write_in, burst_in;
	wire logic bus_grant_ack_n_in, p_ta, p_tea, p_rty, p_bb;
	wire logic [ADDR_W-1:0] addr_in;
	wire logic [DATA_W-1:0] data_in, data_out, slave_wdata_out, wr_data_out;
	wire logic bus_busy_n_out, bus_busy_oe_n_out, bus_owned_out, data_oe_n_out;
	wire logic transfer_ack_n_out, transfer_ack_oe_n_out, rd_ready_out;
	wire logic transfer_error_ack_n_out, transfer_error_ack_oe_n_out;
	wire logic retry_request_n_out, retry_request_oe_n_out, wr_valid_out;
	wire logic dma_request_n_out, slave_beat_out;
	// Pulled-up lines: any driving party wins low
	wire logic transfer_ack_n_in = p_ta &
		(transfer_ack_oe_n_out | transfer_ack_n_out);
	wire logic transfer_error_ack_n_in = p_tea &
		(transfer_error_ack_oe_n_out | transfer_error_ack_n_out);
	wire logic retry_request_n_in = p_rty &
		(retry_request_oe_n_out | retry_request_n_out);
	wire logic bus_busy_n_in = p_bb & (bus_busy_oe_n_out | bus_busy_n_out);
	wire logic [DATA_W-1:0] bus_data = data_oe_n_out ? data_in : data_out;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	int bad = 0;
	int pops = 0;
	int n_rd = 0;
	int beats_seen = 0;
	int beats_exp = 0;
	logic [DATA_W-1:0] got[$];
	logic [DATA_W-1:0] exp_q[$];

	lbsdp_port DUT (.clk_sys_in, .rst_in, .bus_style_in, .own_req_in,
		.bus_busy_n_in, .bus_grant_ack_n_in, .bus_busy_n_out,
		.bus_busy_oe_n_out, .bus_owned_out, .transfer_start_n_in,
		.pci_window_select_n_in, .reg_select_n_in, .dma_acknowledge_n_in,
		.dma_done_n_in, .addr_in, .write_in, .burst_in, .data_in, .data_out,
		.data_oe_n_out, .transfer_ack_n_in, .transfer_ack_n_out,
		.transfer_ack_oe_n_out, .transfer_error_ack_n_in,
		.transfer_error_ack_n_out, .transfer_error_ack_oe_n_out,
		.retry_request_n_in, .retry_request_n_out, .retry_request_oe_n_out,
		.dma_request_n_out, .dma_enable_in, .dma_to_bus_in, .slave_beat_out,
		.slave_wdata_out, .slave_rdata_in, .rd_valid_in, .rd_data_in,
		.rd_ready_out, .wr_valid_out, .wr_data_out, .wr_ready_in);

	lbsdp_proc_model P (.clk_sys_in, .ta_n_in(transfer_ack_n_in),
		.dev_data_in(bus_data), .start_n_out(transfer_start_n_in),
		.win_n_out(pci_window_select_n_in), .reg_n_out(reg_select_n_in),
		.dack_n_out(dma_acknowledge_n_in), .done_n_out(dma_done_n_in),
		.addr_out(addr_in), .write_out(write_in), .burst_out(burst_in),
		.data_out(data_in), .ta_n_out(p_ta), .tea_n_out(p_tea),
		.rty_n_out(p_rty), .bb_n_out(p_bb), .bus_grant_ack_n_out(bus_grant_ack_n_in));

	always #20 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cyc++;
		if (wr_valid_out === 1'b1 && wr_ready_in)
			got.push_back(wr_data_out);
		if (rd_ready_out === 1'b1)
			pops++;
		if (slave_beat_out === 1'b1)
			beats_seen++;
		// Dual must never error or retry; single must leave ack alone
		if (!dma_acknowledge_n_in && (!transfer_error_ack_oe_n_out ||
			!retry_request_oe_n_out || (pci_window_select_n_in &&
			!transfer_ack_oe_n_out)))
			bad++;
		if (cyc == 6000) begin
			n_fail++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, s);
			n_fail++;
		end
	endtask

	task automatic results();
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic int exp_lat(lbsdp_style_t s, logic w, logic b, logic u);
		if (b && u && (s == LBSDP_STYLE_THIRD || (s == LBSDP_STYLE_SECOND && w)))
			return 1 + UNALIGNED_WAITS;
		return 1;
	endfunction

	task automatic dma(input logic dual, input logic rdir, input int term);
		int n, lat, bt;
		logic [31:0] r, d;
		@(posedge clk_sys_in) #1;
		d = $urandom;
		{dma_to_bus_in, rd_valid_in, dma_enable_in} = {rdir, rdir, 1'b1};
		rd_data_in = d;
		n = 0;
		while (dma_request_n_out !== 1'b0 && n < 8) begin
			@(posedge clk_sys_in) #1;
			n++;
		end
		chk("dma_request", 0, dma_request_n_out);
		// Address is random: the device must not decode it
		P.xfer(dual ? 3 : 2, !rdir, 0, $urandom, d, term, $urandom_range(3, 0),
			lat, bt, r);
		{rd_valid_in, dma_enable_in} = 2'h0;
		if (dual)
			chk("dual_ack_wait", 2, lat);
		if (rdir && term == 0)
			chk("dma_rdata", d, r);
		n_rd += (rdir && term == 0);
		if (!rdir && term == 0)
			exp_q.push_back(d);
	endtask

	initial begin
		int i, lat, bt;
		logic [31:0] a, d, r;
		void'($urandom(92));
		repeat (20) @(posedge clk_sys_in);
		#1;
		chk("reset_outs", 5'h1C,
			{transfer_ack_oe_n_out, data_oe_n_out, dma_request_n_out,
			bus_owned_out, wr_valid_out});
		rst_in = 1'b0;
		for (i = 0; i < 2; i++) begin
			P.other(i[0], 1'b0);
			own_req_in = 1'b1;
			repeat (6) begin
				@(posedge clk_sys_in) #1;
				chk("owned_early", 0, bus_owned_out);
			end
			P.other(i[0], 1'b1);
			repeat (3) @(posedge clk_sys_in);
			#1;
			chk("owned", 1, bus_owned_out);
			chk("busy_drive", 0, bus_busy_oe_n_out);
			chk("busy_level", 0, bus_busy_n_out);
			own_req_in = 1'b0;
			repeat (3) @(posedge clk_sys_in);
			#1;
			chk("released", 1, bus_busy_oe_n_out);
		end
		for (i = 0; i < 24; i++) begin
			bus_style_in = lbsdp_style_t'(i % 3);
			a = ($urandom & 32'hFFFFFFF0) | (i[3] ? $urandom_range(15, 1) : 0);
			d = $urandom;
			slave_rdata_in = $urandom;
			P.xfer(0, i[2], !i[4], a, d, 0, 0, lat, bt, r);
			chk("slave_wait", exp_lat(bus_style_in, i[2], !i[4], i[3]),
				lat);
			chk("beats", i[4] ? 1 : BURST_BEATS, bt);
			chk("slave_data", i[2] ? d : slave_rdata_in,
				i[2] ? slave_wdata_out : r);
			beats_exp += i[4] ? 1 : BURST_BEATS;
		end
		for (i = 0; i < 6; i++) begin
			P.xfer(1, i[0], 0, $urandom, $urandom, 0, 0, lat, bt, r);
			chk("reg_wait", 1, lat == 3 || lat == 4);
			beats_exp++;
		end
		bus_style_in = LBSDP_STYLE_SECOND;
		for (i = 0; i < 12; i++)
			dma(i[0], i[1], i[0] ? 0 : (i / 4) % 3);
		// Receiver stalls: two words fit, a third must not be asked for
		wr_ready_in = 1'b0;
		dma(1, 0, 0);
		dma(1, 0, 0);
		@(posedge clk_sys_in) #1;
		{dma_to_bus_in, dma_enable_in} = 2'h1;
		repeat (6) begin
			@(posedge clk_sys_in) #1;
			chk("dma_request_out_full", 1, dma_request_n_out);
		end
		dma_enable_in = 1'b0;
		wr_ready_in = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		#1;
		chk("dma_bad_term", 0, bad);
		chk("rd_pops", n_rd, pops);
		chk("slave_beats", beats_exp, beats_seen);
		chk("words", exp_q.size(), got.size());
		foreach (exp_q[k])
			chk("word", exp_q[k], got[k]);
		results();
	end
endmodule
`default_nettype wire
